/* File: rtl/cmid_cfg.svh */
// Purpose: Constants for the data-move decode and execute block.
// Assumes: One core clock at 200 MHz, asynchronous active-low reset.
// Notes:   Overview of operation list follows.
`ifndef CMID_CFG_SVH
`define CMID_CFG_SVH
`define CMID_PC_W          20
`define CMID_PC_RST        20'h0_0000
`define CMID_FLAGS_RST     5'h00
// Status-low bit positions of the five arithmetic flags.
`define CMID_BIT_S         7
`define CMID_BIT_Z         6
`define CMID_BIT_AUXC      4
`define CMID_BIT_PV        2
`define CMID_BIT_CARRY     0
// Short-direct address ranges.
`define CMID_SA1_LO        16'hFE00
`define CMID_SA1_HI        16'hFEFF
`define CMID_SA2A_LO       16'hFD20
`define CMID_SA2A_HI       16'hFDFF
`define CMID_SA2B_LO       16'hFF00
`define CMID_SA2B_HI       16'hFF1F
// Memory-operand lengths by mode.
`define CMID_LEN_IND_SHORT 3'd1
`define CMID_LEN_IND       3'd2
`define CMID_LEN_BASED     3'd3
`define CMID_LEN_INDEXED   3'd5
`define CMID_LEN_BIDX      3'd2
// Fixed lengths of the other forms.
`define CMID_LEN_ABS16_IMM 3'd5
`define CMID_LEN_ABS24_IMM 3'd6
`define CMID_LEN_W24_IMM   3'd7
`define CMID_LEN_SL_IMM    3'd3
`define CMID_LEN_SL_A      3'd2
`define CMID_LEN_BR8       3'd2
`define CMID_LEN_BR16      3'd3
`define CMID_LEN_ALU       3'd2
`endif

/* File: rtl/cmid_pkg.sv */
// Purpose: Types for the data-move decode and execute block.
// Assumes: Instruction fields are pre-extracted by the fetch stage.
// Notes:   Codes are local to this block.
package cmid_pkg;
    typedef enum logic [3:0] {
        OP_MOV_R_IMM   = 4'b0000,
        OP_MOV_SA_IMM  = 4'b0001,
        OP_MOV_A_R     = 4'b0010,
        OP_MOV_MEM     = 4'b0011,
        OP_WORD_TRANSFER_OP_MEM    = 4'b0100,
        OP_WORD_TRANSFER_OP_SA_IMM = 4'b0101,
        OP_MOV_SAP_IND = 4'b0110,
        OP_MOV_A16_IMM = 4'b0111,
        OP_MOV_A24_IMM = 4'b1000,
        OP_WORD_TRANSFER_OP_A24_IM = 4'b1001,
        OP_LD_SL_IMM   = 4'b1010,
        OP_LD_SL_A     = 4'b1011,
        OP_BR8         = 4'b1100,
        OP_BR16        = 4'b1101,
        OP_ALU         = 4'b1110,
        OP_RESTORE     = 4'b1111
    } cmid_op_e;
    typedef enum logic [1:0] {
        MM_IND    = 2'b00,
        MM_BASED  = 2'b01,
        MM_INDEX  = 2'b10,
        MM_BIDX   = 2'b11
    } cmid_mem_e;
    typedef enum logic [1:0] {
        IM_PLAIN = 2'b00,
        IM_INC   = 2'b01,
        IM_DEC   = 2'b10,
        IM_OTHER = 2'b11
    } cmid_ind_e;
    typedef struct packed {
        cmid_op_e    op;
        cmid_mem_e   mem_mode;
        cmid_ind_e   ind_form;
        logic [1:0]  ptr_sel;
        logic        ptr_short;
        logic [15:0] saddr;
        logic        high_bank;
        logic        parity_mode;
        logic [15:0] data;
        logic        ovf;
        logic        carry_flag;
        logic        aux_carry_flag;
        logic [15:0] disp;
        logic        taken;
    } cmid_instr_s;
    typedef struct packed {
        logic s;
        logic z;
        logic aux_carry_flag;
        logic pv;
        logic carry_flag;
    } cmid_flags_s;
endpackage : cmid_pkg

/* File: rtl/cmid_core.sv */
// Purpose: Length decode, flag update and program-counter step for moves.
// Assumes: One instruction issued per valid cycle from program memory.
// Notes:   Pointer index 0..3 selects pointer_24_a..d.
`timescale 1ns/100ps
`include "cmid_cfg.svh"
module cmid_core
#(
    parameter int PC_W = `CMID_PC_W
)(
    // Clock and reset.
    input  wire logic                  clock_i,
    input  wire logic                  nrst_i,
    // Instruction issue.
    input  wire logic                  issue_valid_i,
    input  wire cmid_pkg::cmid_instr_s issue_i,
    // Pointer registers, full 24 bits each.
    input  wire logic [23:0]           pointer_24_a_i,
    input  wire logic [23:0]           pointer_24_b_i,
    input  wire logic [23:0]           pointer_24_c_i,
    input  wire logic [23:0]           pointer_24_d_i,
    // Separate program counter portion loads.
    input  wire logic                  pc_hi_we_i,
    input  wire logic                  pc_low_word_we_i,
    input  wire logic [15:0]           pc_wdata_i,
    // Results.
    output logic [PC_W-1:0]            pc_o,
    output logic [2:0]                 length_o,
    output cmid_pkg::cmid_flags_s      flags_o,
    output logic [23:0]                mem_addr_o,
    output logic [15:0]                move_data_o,
    output logic                       illegal_o,
    output logic                       done_o
);
    import cmid_pkg::*;

    // Refuse a program counter width that the split loads cannot serve.
    if (PC_W != 20) begin : g_pc_w_check
        $error("cmid_core serves a 20-bit program counter only.");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decode.

    cmid_instr_s ins;
    assign ins = issue_i;

    wire in_sa1 = (ins.saddr >= `CMID_SA1_LO) && (ins.saddr <= `CMID_SA1_HI);
    wire in_sa2 = ((ins.saddr >= `CMID_SA2A_LO) && (ins.saddr <= `CMID_SA2A_HI))
               || ((ins.saddr >= `CMID_SA2B_LO) && (ins.saddr <= `CMID_SA2B_HI));
    wire sa_bad = !in_sa1 && !in_sa2;
    wire sa_long = in_sa1;

    wire is_byte_mv = (ins.op == OP_MOV_MEM);
    wire ptr_ab     = (ins.ptr_sel == 2'd0) || (ins.ptr_sel == 2'd1);
    wire ind_short  = is_byte_mv && ptr_ab && (ins.ind_form != IM_OTHER);

    wire [2:0] mem_len =
        (ins.mem_mode == MM_IND)   ? (ind_short ? `CMID_LEN_IND_SHORT : `CMID_LEN_IND) :
        (ins.mem_mode == MM_BASED) ? `CMID_LEN_BASED :
        (ins.mem_mode == MM_INDEX) ? `CMID_LEN_INDEXED : `CMID_LEN_BIDX;

    function automatic logic [2:0] pick(input logic lng, input logic [2:0] s);
        pick = lng ? 3'(s + 3'd1) : s;
    endfunction : pick

    logic [2:0] len_nxt;
    logic       uses_sa;
    always_comb begin
        uses_sa = 1'b0;
        unique case (ins.op)
            OP_MOV_R_IMM:   len_nxt = pick(ins.high_bank, 3'd2);
            OP_MOV_A_R:     len_nxt = pick(ins.high_bank, 3'd1);
            OP_MOV_SA_IMM: begin
                uses_sa = 1'b1;
                len_nxt = pick(sa_long, 3'd3);
            end
            OP_WORD_TRANSFER_OP_SA_IMM: begin
                uses_sa = 1'b1;
                len_nxt = pick(sa_long, 3'd4);
            end
            OP_MOV_SAP_IND: begin
                uses_sa = 1'b1;
                len_nxt = pick(sa_long, 3'd2);
            end
            OP_MOV_MEM:     len_nxt = mem_len;
            OP_WORD_TRANSFER_OP_MEM:    len_nxt = mem_len;
            OP_MOV_A16_IMM: len_nxt = `CMID_LEN_ABS16_IMM;
            OP_MOV_A24_IMM: len_nxt = `CMID_LEN_ABS24_IMM;
            OP_WORD_TRANSFER_OP_A24_IM: len_nxt = `CMID_LEN_W24_IMM;
            OP_LD_SL_IMM:   len_nxt = `CMID_LEN_SL_IMM;
            OP_LD_SL_A:     len_nxt = `CMID_LEN_SL_A;
            OP_BR8:         len_nxt = `CMID_LEN_BR8;
            OP_BR16:        len_nxt = `CMID_LEN_BR16;
            OP_ALU:         len_nxt = `CMID_LEN_ALU;
            OP_RESTORE:     len_nxt = `CMID_LEN_ALU;
        endcase
    end

    wire bad_nxt = uses_sa && sa_bad;

    ////////////////////////////////////////////////////////////////////////////
    // Pointer address, always the full 24-bit register.

    wire [23:0] ptr_full = (ins.ptr_sel == 2'd0) ? pointer_24_a_i :
                           (ins.ptr_sel == 2'd1) ? pointer_24_b_i :
                           (ins.ptr_sel == 2'd2) ? pointer_24_c_i : pointer_24_d_i;

    ////////////////////////////////////////////////////////////////////////////
    // Program counter step and branch target.

    logic [PC_W-1:0] pc_r;
    wire  [PC_W-1:0] pc_next_start = PC_W'(pc_r + {17'd0, len_nxt});
    wire  [PC_W-1:0] disp_ext = (ins.op == OP_BR8) ?
                                {{(PC_W-8){ins.disp[7]}}, ins.disp[7:0]} :
                                {{(PC_W-16){ins.disp[15]}}, ins.disp};
    wire  is_branch = (ins.op == OP_BR8) || (ins.op == OP_BR16);
    wire  [PC_W-1:0] pc_nxt = (is_branch && ins.taken) ?
                              PC_W'(pc_next_start + disp_ext) : pc_next_start;

    ////////////////////////////////////////////////////////////////////////////
    // Flag update.

    cmid_flags_s flags_r;
    cmid_flags_s saved_r;
    wire [7:0]   res8 = ins.data[7:0];
    wire         par_even = ~^res8;
    wire         pv_val = ins.parity_mode ? par_even : ins.ovf;
    cmid_flags_s alu_flags;
    assign alu_flags = '{s: res8[7], z: (res8 == 8'h00), aux_carry_flag: ins.aux_carry_flag,
                         pv: pv_val, carry_flag: ins.carry_flag};
    cmid_flags_s load_flags;
    assign load_flags = '{s: res8[`CMID_BIT_S], z: res8[`CMID_BIT_Z],
                          aux_carry_flag: res8[`CMID_BIT_AUXC],
                          pv: res8[`CMID_BIT_PV], carry_flag: res8[`CMID_BIT_CARRY]};
    wire is_sl_load = (ins.op == OP_LD_SL_IMM) || (ins.op == OP_LD_SL_A);
    cmid_flags_s flags_nxt;
    assign flags_nxt = is_sl_load              ? load_flags :
                       (ins.op == OP_ALU)      ? alu_flags  :
                       (ins.op == OP_RESTORE)  ? saved_r    :
                       flags_r;

    wire [15:0] data_nxt = (ins.op == OP_WORD_TRANSFER_OP_MEM || ins.op == OP_WORD_TRANSFER_OP_SA_IMM ||
                            ins.op == OP_WORD_TRANSFER_OP_A24_IM) ? ins.data : {8'h00, ins.data[7:0]};

    ////////////////////////////////////////////////////////////////////////////
    // Registers.

    wire take = issue_valid_i && !bad_nxt;

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pc_r <= `CMID_PC_RST;
        end else if (take) begin
            pc_r <= pc_nxt;
        end else begin
            if (pc_hi_we_i) begin
                pc_r[19:16] <= pc_wdata_i[3:0];
            end
            if (pc_low_word_we_i) begin
                pc_r[15:0] <= pc_wdata_i;
            end
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flags_r <= `CMID_FLAGS_RST;
            saved_r <= `CMID_FLAGS_RST;
        end else if (take) begin
            flags_r <= flags_nxt;
            if (ins.op == OP_ALU) begin
                saved_r <= flags_r;
            end
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            length_o    <= 3'd0;
            mem_addr_o  <= 24'h00_0000;
            move_data_o <= 16'h0000;
            illegal_o   <= 1'b0;
            done_o      <= 1'b0;
        end else begin
            done_o    <= take;
            illegal_o <= issue_valid_i && bad_nxt;
            if (take) begin
                length_o    <= len_nxt;
                mem_addr_o  <= ptr_full;
                move_data_o <= data_nxt;
            end
        end
    end

    assign pc_o    = pc_r;
    assign flags_o = flags_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    flag_keep_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        issue_valid_i && (ins.op == OP_MOV_MEM || ins.op == OP_MOV_R_IMM) |=> $stable(flags_o))
        else $error("Byte move changed flags.");
    word_keep_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        issue_valid_i && ins.op == OP_WORD_TRANSFER_OP_MEM |=> $stable(flags_o)
            && move_data_o == $past(ins.data))
        else $error("Word move changed flags or data.");
    sl_load_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        issue_valid_i && is_sl_load |=> flags_o.carry_flag == $past(res8[`CMID_BIT_CARRY])
            && flags_o.s == $past(res8[`CMID_BIT_S]))
        else $error("Status-low load did not rewrite flags.");
    pv_mode_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        issue_valid_i && ins.op == OP_ALU && ins.parity_mode |=> flags_o.pv == $past(par_even))
        else $error("Parity flag wrong.");
    br_target_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        issue_valid_i && ins.op == OP_BR8 && ins.taken |=>
            pc_o == PC_W'($past(pc_o) + 20'd2 + {{12{$past(ins.disp[7])}}, $past(ins.disp[7:0])}))
        else $error("Short branch target wrong.");
    pc_step_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        take && !is_branch |=> pc_o == PC_W'($past(pc_o) + {17'd0, length_o}))
        else $error("Counter did not advance by length.");
    ind_short_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        issue_valid_i && ins.op == OP_WORD_TRANSFER_OP_MEM && ins.mem_mode == MM_IND |=> length_o == 3'd2)
        else $error("Word indirect took one byte.");
    idx_len_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        issue_valid_i && ins.op == OP_MOV_MEM && ins.mem_mode == MM_INDEX |=> length_o == 3'd5)
        else $error("Indexed length wrong.");
    sa_len_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        issue_valid_i && ins.op == OP_MOV_SA_IMM && in_sa1 |=> length_o == 3'd4)
        else $error("First range must take the longer form.");
    ptr_full_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        take && ins.ptr_short && ins.ptr_sel == 2'd1 |=> mem_addr_o == $past(pointer_24_b_i))
        else $error("Short pointer name lost upper byte.");
    pc_split_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        !issue_valid_i && pc_hi_we_i && !pc_low_word_we_i |=> pc_o[15:0] == $past(pc_o[15:0]))
        else $error("Upper load disturbed low word.");
endmodule : cmid_core

/* File: bench/cmid_prog_mem.sv */
// Purpose: Program memory model that hands instructions to the decode block.
// Assumes: One instruction per fetch cycle, no wait states.
// Notes:   Idle cycles show a toggling pattern, never the last instruction.
`timescale 1ns/100ps
module cmid_prog_mem (
    // Clock and reset.
    input  wire logic                  clock_i,
    input  wire logic                  nrst_i,
    // Bench request.
    input  wire logic                  fetch_i,
    input  wire cmid_pkg::cmid_instr_s word_i,
    // Issue towards the core.
    output logic                       issue_valid_o,
    output cmid_pkg::cmid_instr_s      issue_o
);
    import cmid_pkg::*;
    cmid_instr_s idle_r;
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            idle_r <= '1;
        end else begin
            idle_r <= ~idle_r;
        end
    end
    assign issue_valid_o = fetch_i;
    assign issue_o       = fetch_i ? word_i : idle_r;
endmodule : cmid_prog_mem

/* File: bench/tb.sv */
// Purpose: Self-checking bench for the data-move decode block.
// Assumes: Inputs change at the falling clock edge.
// Notes:   A reference model in the bench tracks every output.
`timescale 1ns/100ps
module tb;
    import cmid_pkg::*;
    logic        clock_i = 1'b0, nrst_i = 1'b0, fetch = 1'b0, hi_we = 1'b0, lo_we = 1'b0;
    logic [15:0] wdata   = 16'h0000;
    cmid_instr_s word    = '0, ins;
    logic [23:0] ptr [4] = '{24'h00_0000, 24'h00_0000, 24'h00_0000, 24'h00_0000};
    logic [31:0] seed    = 32'h0001_1165, rnd_a, rnd_b;
    int          failures = 0, n_tests = 0;
    wire logic   issue_valid, illegal_o, done_o;
    cmid_instr_s issue;
    wire logic [19:0] pc_o;
    wire logic [2:0]  length_o;
    cmid_flags_s      flags_o;
    wire logic [23:0] mem_addr_o;
    wire logic [15:0] move_data_o;
    logic [19:0] m_pc;
    logic [2:0]  m_len;
    logic [4:0]  m_fl, m_sv;
    logic [23:0] m_addr;
    logic [15:0] m_data;
    logic        m_done, m_ill;
    logic [15:0] sa_tab [8] = '{16'hFD1F, 16'hFD20, 16'hFDFF, 16'hFE00,
                                16'hFEFF, 16'hFF00, 16'hFF1F, 16'hFF20};
    always #2.5 clock_i = ~clock_i;
    cmid_prog_mem u_cmid_prog_mem (.clock_i(clock_i), .nrst_i(nrst_i), .fetch_i(fetch),
        .word_i(word), .issue_valid_o(issue_valid), .issue_o(issue));
    cmid_core u_cmid_core (.clock_i(clock_i), .nrst_i(nrst_i), .issue_valid_i(issue_valid),
        .issue_i(issue), .pointer_24_a_i(ptr[0]), .pointer_24_b_i(ptr[1]),
        .pointer_24_c_i(ptr[2]), .pointer_24_d_i(ptr[3]), .pc_hi_we_i(hi_we),
        .pc_low_word_we_i(lo_we), .pc_wdata_i(wdata), .pc_o(pc_o), .length_o(length_o),
        .flags_o(flags_o), .mem_addr_o(mem_addr_o), .move_data_o(move_data_o),
        .illegal_o(illegal_o), .done_o(done_o));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [2:0] len_of(input cmid_instr_s i);
        logic lng;
        lng = (i.saddr >= 16'hFE00) && (i.saddr <= 16'hFEFF);
        case (i.op)
            OP_MOV_R_IMM:   return i.high_bank ? 3'd3 : 3'd2;
            OP_MOV_A_R:     return i.high_bank ? 3'd2 : 3'd1;
            OP_MOV_SA_IMM:  return lng ? 3'd4 : 3'd3;
            OP_WORD_TRANSFER_OP_SA_IMM: return lng ? 3'd5 : 3'd4;
            OP_MOV_SAP_IND: return lng ? 3'd3 : 3'd2;
            OP_MOV_MEM, OP_WORD_TRANSFER_OP_MEM: begin
                case (i.mem_mode)
                    MM_IND:   return (i.op == OP_MOV_MEM && i.ptr_sel < 2'd2 &&
                                      i.ind_form != IM_OTHER) ? 3'd1 : 3'd2;
                    MM_BASED: return 3'd3;
                    MM_INDEX: return 3'd5;
                    default:  return 3'd2;
                endcase
            end
            OP_MOV_A16_IMM: return 3'd5;
            OP_MOV_A24_IMM: return 3'd6;
            OP_WORD_TRANSFER_OP_A24_IM: return 3'd7;
            OP_LD_SL_IMM, OP_BR16: return 3'd3;
            default:        return 3'd2;
        endcase
    endfunction : len_of
    function automatic cmid_instr_s mk(input cmid_op_e op, input cmid_mem_e mm,
        input cmid_ind_e ind, input logic [1:0] ps, input logic [15:0] sa, input logic hb,
        input logic [15:0] d, input logic [15:0] disp, input logic tk);
        cmid_instr_s i;
        i = '0;
        i.op = op;
        i.mem_mode = mm;
        i.ind_form = ind;
        i.ptr_sel = ps;
        i.saddr = sa;
        i.high_bank = hb;
        i.data = d;
        i.disp = disp;
        i.taken = tk;
        return i;
    endfunction : mk
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic step(input logic vv, input cmid_instr_s i, input logic hw, input logic lw,
        input logic [15:0] wd);
        @(negedge clock_i);
        check(24'(done_o), 24'(m_done));
        check(24'(illegal_o), 24'(m_ill));
        check(24'(pc_o), 24'(m_pc));
        check(24'(length_o), 24'(m_len));
        check(24'(flags_o), 24'(m_fl));
        check(mem_addr_o, m_addr);
        check(24'(move_data_o), 24'(m_data));
        fetch = vv;
        word = i;
        hi_we = hw;
        lo_we = lw;
        wdata = wd;
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            ptr[k] = seed[23:0];
        end
        m_ill  = vv && (i.op inside {OP_MOV_SA_IMM, OP_WORD_TRANSFER_OP_SA_IMM, OP_MOV_SAP_IND}) &&
                 !(i.saddr >= 16'hFD20 && i.saddr <= 16'hFF1F);
        m_done = vv && !m_ill;
        if (m_done) begin
            m_len  = len_of(i);
            m_addr = ptr[i.ptr_sel];
            m_data = (i.op inside {OP_WORD_TRANSFER_OP_MEM, OP_WORD_TRANSFER_OP_SA_IMM, OP_WORD_TRANSFER_OP_A24_IM}) ?
                     i.data : {8'h00, i.data[7:0]};
            m_pc   = m_pc + 20'(m_len);
            if (i.taken && i.op == OP_BR8) m_pc = m_pc + {{12{i.disp[7]}}, i.disp[7:0]};
            if (i.taken && i.op == OP_BR16) m_pc = m_pc + {{4{i.disp[15]}}, i.disp};
            if (i.op inside {OP_LD_SL_IMM, OP_LD_SL_A})
                m_fl = {i.data[7], i.data[6], i.data[4], i.data[2], i.data[0]};
            if (i.op == OP_ALU) begin
                m_sv = m_fl;
                m_fl = {i.data[7], i.data[7:0] == 8'h00, i.aux_carry_flag,
                        i.parity_mode ? ~^i.data[7:0] : i.ovf, i.carry_flag};
            end
            if (i.op == OP_RESTORE) m_fl = m_sv;
        end else begin
            if (hw) m_pc[19:16] = wd[3:0];
            if (lw) m_pc[15:0] = wd;
        end
    endtask : step
    task automatic do_reset;
        @(negedge clock_i);
        nrst_i = 1'b0;
        fetch = 1'b0;
        hi_we = 1'b0;
        lo_we = 1'b0;
        repeat (4) @(negedge clock_i);
        nrst_i = 1'b1;
        m_pc = '0;
        m_len = '0;
        m_fl = '0;
        m_sv = '0;
        m_addr = '0;
        m_data = '0;
        m_done = 1'b0;
        m_ill = 1'b0;
    endtask : do_reset
    task automatic conclude;
        if (failures == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #20000;
        failures++;
        conclude();
    end
    initial begin
        do_reset();
        for (int k = 0; k < 16; k++)
            step(1'b1, mk(OP_MOV_MEM, MM_IND, cmid_ind_e'(k[1:0]), k[3:2], 0, 0, 16'h1234, 0, 0),
                 0, 0, 0);
        for (int k = 0; k < 4; k++)
            step(1'b1, mk(OP_WORD_TRANSFER_OP_MEM, cmid_mem_e'(k[1:0]), IM_PLAIN, 0, 0, 0, 16'hBEEF, 0, 0),
                 0, 0, 0);
        for (int k = 0; k < 24; k++)
            step(1'b1, mk(cmid_op_e'(k % 3 == 0 ? 1 : k % 3 == 1 ? 5 : 6), MM_IND, IM_PLAIN, 0,
                 sa_tab[k % 8], 0, 16'hA55A, 0, 0), 0, 0, 0);
        for (int k = 0; k < 16; k++)
            step(1'b1, mk(cmid_op_e'(k), MM_BASED, IM_PLAIN, 2'(k), 16'hFE00, k[0],
                 16'h5AD5, 0, 0), 0, 0, 0);
        ins = mk(OP_ALU, MM_IND, IM_PLAIN, 0, 0, 0, 16'h0003, 0, 0);
        ins.parity_mode = 1'b1;
        ins.carry_flag = 1'b1;
        step(1'b1, ins, 0, 0, 0);
        ins.parity_mode = 1'b0;
        ins.ovf = 1'b1;
        ins.data = 16'h0080;
        step(1'b1, ins, 0, 0, 0);
        step(1'b1, mk(OP_RESTORE, MM_IND, IM_PLAIN, 0, 0, 0, 0, 0, 0), 0, 0, 0);
        step(1'b0, '0, 1, 1, 16'h0003);
        step(1'b1, mk(OP_BR8, MM_IND, IM_PLAIN, 0, 0, 0, 0, 16'h0080, 1), 0, 0, 0);
        step(1'b1, mk(OP_BR16, MM_IND, IM_PLAIN, 0, 0, 0, 0, 16'h8000, 1), 0, 0, 0);
        step(1'b1, mk(OP_BR8, MM_IND, IM_PLAIN, 0, 0, 0, 0, 16'h007F, 0), 0, 0, 0);
        step(1'b0, '0, 1, 0, 16'h000F);
        step(1'b0, '0, 0, 1, 16'hFFFE);
        step(1'b1, mk(OP_BR16, MM_IND, IM_PLAIN, 0, 0, 0, 0, 16'h0010, 1), 1, 1, 16'h1234);
        step(1'b0, '0, 0, 0, 0);
        do_reset();
        for (int k = 0; k < 400; k++) begin
            seed = lfsr(seed);
            rnd_a = seed;
            seed = lfsr(seed);
            rnd_b = seed;
            seed = lfsr(seed);
            ins = cmid_instr_s'({rnd_a, rnd_b, seed[0]});
            if (seed[5:2] != 4'h0) ins.saddr = 16'hFD20 + {7'h00, seed[16:8]};
            step(seed[20] | seed[21], ins, ~(seed[20] | seed[21]) & seed[22],
                 ~(seed[20] | seed[21]) & seed[23], seed[31:16]);
        end
        step(1'b0, '0, 0, 0, 0);
        conclude();
    end
endmodule : tb
